//--- logic/frrc_pkg.sv
/*
 * Constants and types for the fault restart retry controller.
 * Assumes a single 20 MHz core clock; time units are whole microseconds.
 */
package frrc_pkg;

    // clock rate, 50 ns period
    localparam int unsigned CLK_MHZ     = 20;

    // retry setting codes
    localparam logic [1:0]  RETRY_NONE  = 2'h0;
    localparam logic [1:0]  RETRY_ONCE  = 2'h1;
    localparam logic [1:0]  RETRY_TWICE = 2'h2;
    localparam logic [1:0]  RETRY_THREE = 2'h3;

    // delay field width, bits [2:0]
    localparam int unsigned DELAY_W     = 3;

    // selectable delay time units, in microseconds
    localparam int unsigned UNIT0_US    = 10;
    localparam int unsigned UNIT1_US    = 100;
    localparam int unsigned UNIT2_US    = 1000;
    localparam int unsigned UNIT3_US    = 10000;

    // the same units as core clock cycles
    localparam int unsigned UNIT0_CYCLES = UNIT0_US * CLK_MHZ;
    localparam int unsigned UNIT1_CYCLES = UNIT1_US * CLK_MHZ;
    localparam int unsigned UNIT2_CYCLES = UNIT2_US * CLK_MHZ;
    localparam int unsigned UNIT3_CYCLES = UNIT3_US * CLK_MHZ;

    // prescaler width, covers the largest unit
    localparam int unsigned PRE_W       = 18;

    // reset values
    localparam logic [PRE_W-1:0]   PRE_RST   = 18'h00000;
    localparam logic [DELAY_W-1:0] TICK_RST  = 3'h0;
    localparam logic [1:0]         LEFT_RST  = 2'h0;

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_ON   = 2'b01,
        ST_WAIT = 2'b10,
        ST_LOCK = 2'b11
    } frrc_state_t;

endpackage

//--- logic/frrc_retry_ctrl.sv
/*
 * Fault restart retry controller: turns the converter output back on a
 * configured number of times after a fault, spaced by delay times unit.
 * Assumes retry_mode, retry_delay, unit_sel, run_req and fault_clear come
 * from logic on core_clk; fault_in is an asynchronous detector level.
 * A fault still in the synchroniser when a zero-delay attempt starts fails
 * that attempt too; real delays are far longer than the two-cycle tail.
 */
`timescale 1ns/10ps

// Contract
// [RULE1] With the no-restart setting a fault turns the output off and it stays off until cleared.
// [RULE2] With the single-retry setting exactly one restart attempt follows the fault.
// [RULE3] With the double-retry setting exactly two restart attempts follow the fault.
// [RULE4] With the triple-retry setting exactly three restart attempts follow the fault.
// [RULE5] Once all attempts fail the output stays off with no more attempts until cleared.
// [RULE6] Starts of consecutive attempts are spaced by the delay field times the selected unit.
// [RULE7] A fault seen during or after an attempt fails it and starts the next wait or lockout.
module frrc_retry_ctrl
    import frrc_pkg::*;
#(
    parameter int unsigned UNIT0_CYC = UNIT0_CYCLES,
    parameter int unsigned UNIT1_CYC = UNIT1_CYCLES,
    parameter int unsigned UNIT2_CYC = UNIT2_CYCLES,
    parameter int unsigned UNIT3_CYC = UNIT3_CYCLES
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               fault_in,
    input  wire logic               run_req,
    input  wire logic               fault_clear,
    input  wire logic [1:0]         retry_mode,
    input  wire logic [DELAY_W-1:0] retry_delay,
    input  wire logic [1:0]         unit_sel,
    output logic                    output_enable,
    output logic                    restart_pulse,
    output logic                    retry_locked,
    output logic [1:0]              retries_left
);

    frrc_state_t          state_reg;
    frrc_state_t          state_next;
    logic                 fault_meta_reg;
    logic                 fault_sync_reg;
    logic                 seq_active_reg;
    logic [1:0]           left_reg;
    logic [1:0]           left_next;
    logic [1:0]           avail;
    logic                 tmr_start;
    logic                 tmr_done_reg;
    logic [PRE_W-1:0]     pre_cnt_reg;
    logic [PRE_W-1:0]     unit_last_reg;
    logic [PRE_W-1:0]     unit_last_sel;
    logic [DELAY_W-1:0]   tick_cnt_reg;
    logic                 unit_tick;
    logic                 fault_seen;

    // fault detector is asynchronous to core_clk
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_meta_reg <= 1'b0;
            fault_sync_reg <= 1'b0;
        end else begin
            fault_meta_reg <= fault_in;
            fault_sync_reg <= fault_meta_reg;
        end
    end

    // last prescaler count of the chosen unit
    always_comb begin
        case (unit_sel)
            2'h0:    unit_last_sel = PRE_W'(UNIT0_CYC - 1);
            2'h1:    unit_last_sel = PRE_W'(UNIT1_CYC - 1);
            2'h2:    unit_last_sel = PRE_W'(UNIT2_CYC - 1);
            default: unit_last_sel = PRE_W'(UNIT3_CYC - 1);
        endcase
    end

    // attempts still allowed; a fresh sequence takes the setting itself
    always_comb begin
        avail = seq_active_reg ? left_reg : retry_mode; // RULE2 RULE3 RULE4
    end

    // output on and a synchronised fault: the running attempt has failed
    always_comb begin
        fault_seen = (state_reg == ST_ON) && fault_sync_reg; // RULE7
    end

    always_comb begin
        state_next = state_reg;
        left_next  = left_reg;
        tmr_start  = 1'b0;
        case (state_reg)
            ST_OFF: begin
                if (run_req && !fault_sync_reg && !fault_clear) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (fault_sync_reg) begin
                    if (avail == RETRY_NONE) begin
                        state_next = ST_LOCK; // RULE1 RULE5 RULE7
                    end else begin
                        state_next = ST_WAIT; // RULE7
                        left_next  = avail - 2'h1;
                        // first fault opens the interval; later ones reuse it
                        tmr_start  = !seq_active_reg; // RULE6
                    end
                end else if (!run_req) begin
                    state_next = ST_OFF;
                end
            end
            ST_WAIT: begin
                // detector not read here: the failure was counted on leaving ON
                if (fault_clear || !run_req) begin
                    state_next = ST_OFF;
                end else if (tmr_done_reg) begin
                    state_next = ST_ON;
                    tmr_start  = 1'b1; // RULE6
                end
            end
            ST_LOCK: begin
                // no path out but an explicit clear
                if (fault_clear) begin
                    state_next = ST_OFF; // RULE5
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // sequence stays open until cleared, so a late fault cannot refill retries
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            seq_active_reg <= 1'b0;
        end else if (fault_clear) begin
            seq_active_reg <= 1'b0;
        end else if (fault_seen) begin
            seq_active_reg <= 1'b1;
        end
    end

    // clear beats a coincident fault here, so the count restarts from the setting
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            left_reg <= LEFT_RST;
        end else if (fault_clear) begin
            left_reg <= LEFT_RST;
        end else if (fault_seen) begin
            left_reg <= left_next; // RULE2 RULE3 RULE4
        end
    end

    // unit boundary; the prescaler only runs while an interval is open
    always_comb begin
        unit_tick = !tmr_done_reg && (pre_cnt_reg >= unit_last_reg);
    end

    // first unit starts at one so the registered done flag costs no extra cycle;
    // compare is >= so a one-cycle unit cannot wrap the prescaler
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pre_cnt_reg   <= PRE_RST;
            unit_last_reg <= PRE_RST;
        end else if (tmr_start) begin
            pre_cnt_reg   <= PRE_RST + 18'h00001;
            unit_last_reg <= unit_last_sel;
        end else if (unit_tick) begin
            pre_cnt_reg   <= PRE_RST;
        end else if (!tmr_done_reg) begin
            pre_cnt_reg   <= pre_cnt_reg + 18'h00001;
        end
    end

    // interval in whole units, first fault to first attempt start, then attempt start to attempt start
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tick_cnt_reg <= TICK_RST;
            tmr_done_reg <= 1'b1;
        end else if (tmr_start) begin
            tick_cnt_reg <= retry_delay; // RULE6
            tmr_done_reg <= (retry_delay == TICK_RST);
        end else if (unit_tick) begin
            tick_cnt_reg <= tick_cnt_reg - 3'h1;
            if (tick_cnt_reg == 3'h1) begin
                tmr_done_reg <= 1'b1; // RULE6
            end
        end
    end

    // outputs registered from the next state, so they change with it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            output_enable <= 1'b0;
            retry_locked  <= 1'b0;
            restart_pulse <= 1'b0;
        end else begin
            output_enable <= (state_next == ST_ON); // RULE1 RULE5
            retry_locked  <= (state_next == ST_LOCK); // RULE5
            restart_pulse <= (state_reg == ST_WAIT) && (state_next == ST_ON);
        end
    end

    // mirrors left_reg, but reads zero after a no-retry lockout
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            retries_left <= LEFT_RST;
        end else if (fault_clear) begin
            retries_left <= LEFT_RST;
        end else if (fault_seen) begin
            retries_left <= (avail == RETRY_NONE) ? LEFT_RST : left_next;
        end
    end

endmodule

//--- tb/frrc_asserts.sv
/*
 * Concurrent checks for the retry controller, bound to frrc_retry_ctrl.
 * Assumes only its ports are visible and one core_clk domain.
 */
`timescale 1ns/10ps
module frrc_asserts
    import frrc_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       fault_in,
    input wire logic       run_req,
    input wire logic       fault_clear,
    input wire logic [1:0] retries_left,
    input wire logic       output_enable,
    input wire logic       restart_pulse,
    input wire logic       retry_locked
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // output held on through three synchroniser samples of the fault
    sequence fault_held;
        (output_enable && fault_in) [*3];
    endsequence

    fault_drop_a: assert property (fault_held |=> !output_enable)
        else $error("output stayed on through a fault");
    lock_off_a: assert property (retry_locked |-> !output_enable)
        else $error("output on while locked");
    lock_hold_a: assert property (retry_locked && !fault_clear |=> retry_locked)
        else $error("lockout left without clear");
    clear_unlock_a: assert property (retry_locked && fault_clear |=> !retry_locked)
        else $error("lockout kept after clear");
    lock_cause_a: assert property ($rose(retry_locked) |-> $fell(output_enable))
        else $error("lockout without a failed attempt");
    pulse_rise_a: assert property (restart_pulse |-> output_enable && !$past(output_enable))
        else $error("restart pulse without output rise");
    pulse_count_a: assert property (restart_pulse |-> $stable(retries_left))
        else $error("retry count moved at attempt start");
    lock_empty_a: assert property (retry_locked |-> retries_left == 2'h0)
        else $error("retries left while locked");
    lock_run_a: assert property (retry_locked && run_req && !fault_clear |=> !output_enable)
        else $error("output restarted from lockout");
endmodule

bind frrc_retry_ctrl frrc_asserts frrc_asserts_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .fault_in(fault_in), .run_req(run_req),
    .fault_clear(fault_clear), .retries_left(retries_left), .output_enable(output_enable),
    .restart_pulse(restart_pulse), .retry_locked(retry_locked)
);

//--- tb/frrc_fault_src.sv
/*
 * Converter model: a persistent fault that reappears whenever the output is on.
 * Assumes arm comes from the bench; fault_in drives the controller.
 */
`timescale 1ns/10ps
module frrc_fault_src (
    input wire logic core_clk,
    input wire logic arm,
    input wire logic output_enable,
    output logic     fault_in = 1'b0
);
    // every attempt fails; updated on the rising edge by non-blocking
    // assignment so the bench's falling-edge change of arm never races it
    always @(posedge core_clk) begin
        fault_in <= arm & output_enable;
    end
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking bench for the retry controller with small time units.
 * Assumes frrc_fault_src as the converter and the bench as configuring host.
 */
`timescale 1ns/10ps
module tb_top;
    import frrc_pkg::*;
    logic core_clk = 0, sys_rst = 1, run_req = 0, fault_clear = 0, arm = 0;
    logic [1:0] retry_mode = 0, unit_sel = 0, retries_left;
    logic [2:0] retry_delay = 0;
    logic fault_in, output_enable, restart_pulse, retry_locked;
    int n_errors = 0, check_count = 0, cyc = 0, i;
    logic [31:0] seed = 32'h000179FA;

    frrc_retry_ctrl #(.UNIT0_CYC(2), .UNIT1_CYC(3), .UNIT2_CYC(4), .UNIT3_CYC(5))
        frrc_retry_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .fault_in(fault_in),
        .run_req(run_req), .fault_clear(fault_clear), .retry_mode(retry_mode),
        .retry_delay(retry_delay), .unit_sel(unit_sel), .output_enable(output_enable),
        .restart_pulse(restart_pulse), .retry_locked(retry_locked),
        .retries_left(retries_left));
    frrc_fault_src frrc_fault_src_i (.core_clk(core_clk), .arm(arm),
        .output_enable(output_enable), .fault_in(fault_in));

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13); s = s ^ (s >> 17); s = s ^ (s << 5);
        return s;
    endfunction
    // unit sizes set above are 2..5 cycles; a zero delay still costs one cycle
    function int exp_gap(input int d, input int u);
        return (d == 0) ? 1 : d * (u + 2);
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task trial(input logic [1:0] m, input logic [2:0] d, input logic [1:0] u);
        int pulses, t_off, gap, k;
        pulses = 0; gap = -1;
        @(negedge core_clk); retry_mode = m; retry_delay = d; unit_sel = u;
        fault_clear = 1; run_req = 1;
        @(negedge core_clk); fault_clear = 0;
        repeat (3) @(negedge core_clk);
        check(output_enable, 1);
        arm = 1;
        k = 0;
        while (output_enable === 1'b1 && k < 10) begin @(negedge core_clk); k++; end
        t_off = cyc;
        check(retries_left, (m == 2'h0) ? 2'h0 : m - 2'h1);
        k = 0;
        while (retry_locked !== 1'b1 && k < 3000) begin
            @(negedge core_clk); k++;
            if (restart_pulse === 1'b1) begin
                pulses++;
                if (gap < 0) gap = cyc - t_off;
            end
        end
        check(pulses, m);
        if (m != 0) check(gap, exp_gap(d, u));
        repeat (20) @(negedge core_clk);
        check({retry_locked, output_enable, restart_pulse}, 3'h4);
        arm = 0; fault_clear = 1;
        @(negedge core_clk); fault_clear = 0; run_req = 0;
        @(negedge core_clk); check(retry_locked, 0);
        repeat (4) @(negedge core_clk);
    endtask
    // clear while waiting for the first retry: back to off, then a plain start
    task abort_wait;
        @(negedge core_clk); retry_mode = 2'h3; retry_delay = 3'h7; unit_sel = 2'h3;
        fault_clear = 1; run_req = 1;
        @(negedge core_clk); fault_clear = 0;
        repeat (3) @(negedge core_clk);
        arm = 1;
        repeat (6) @(negedge core_clk);
        check({output_enable, retries_left}, 3'h2);
        arm = 0; fault_clear = 1;
        @(negedge core_clk); fault_clear = 0;
        @(negedge core_clk);
        check({output_enable, restart_pulse, retries_left}, 4'h8);
        run_req = 0;
        repeat (2) @(negedge core_clk);
    endtask

    initial begin
        repeat (20) @(negedge core_clk);
        sys_rst = 0;
        trial(2'h0, 3'h1, 2'h0);
        trial(2'h3, 3'h7, 2'h3);
        trial(2'h2, 3'h0, 2'h1);
        abort_wait();
        for (i = 0; i < 12; i++) begin
            seed = xs(seed);
            trial(seed[1:0], (seed[4:2] == 3'h0) ? 3'h1 : seed[4:2], seed[6:5]);
        end
        summarize();
    end
    // the trials need a few thousand cycles at most
    initial begin
        #(50 * 20000);
        n_errors++;
        summarize();
    end
endmodule
